// [logic/lcw_pkg.sv]
// constants and types for the local connection word decoder
package lcw_pkg;
    // ------------------------------------------------------------
    // register map and sizes
    // ------------------------------------------------------------
    localparam int LCW_IDX_W = 5;
    localparam int LCW_CHANS = 32;
    localparam logic [7:0] LCW_REG_CONN = 8'h00;
    localparam logic [7:0] LCW_REG_CTRL = 8'h20;
    localparam logic [7:0] LCW_REG_STAT = 8'h21;
    localparam logic [7:0] LCW_REG_SEED = 8'h22;
    // ------------------------------------------------------------
    // connection word fields
    // ------------------------------------------------------------
    localparam int LCW_MODE_HI = 15;
    localparam int LCW_MODE_LO = 13;
    localparam int LCW_STRM_HI = 12;
    localparam int LCW_STRM_LO = 8;
    localparam int LCW_CHAN_HI = 7;
    localparam int LCW_CHAN_LO = 0;
    // control fields
    localparam int LCW_CTRL_RATE_LO = 0;
    localparam int LCW_CTRL_BP16 = 3;
    localparam int LCW_CTRL_RUN = 4;
    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [15:0] LCW_CONN_RST = 16'hC000;
    localparam logic [15:0] LCW_CTRL_RST = 16'h0000;
    localparam logic [7:0] LCW_SEED_RST = 8'h01;
    localparam logic [7:0] LCW_LFSR_TAPS = 8'hB8;
    // streams held low at 4 and 8 Mb/s local rates
    localparam logic [4:0] LCW_LOW_FIRST = 5'h13;
    localparam logic [4:0] LCW_LOW_LAST = 5'h1B;
    // selector widths per source rate
    localparam logic [3:0] LCW_SW_FULL = 4'h5;
    localparam logic [3:0] LCW_SW_HALF = 4'h4;
    localparam logic [3:0] LCW_CW_32 = 4'h5;
    localparam logic [3:0] LCW_CW_64 = 4'h6;
    localparam logic [3:0] LCW_CW_128 = 4'h7;
    localparam logic [3:0] LCW_CW_256 = 4'h8;
    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        LCW_MODE_LOC_VAR = 3'b000,
        LCW_MODE_LOC_CONST = 3'b001,
        LCW_MODE_BP_VAR = 3'b010,
        LCW_MODE_BP_CONST = 3'b011,
        LCW_MODE_MESSAGE = 3'b100,
        LCW_MODE_PATTERN = 3'b101,
        LCW_MODE_FLOAT = 3'b110,
        LCW_MODE_RSVD = 3'b111
    } lcw_mode_t;
    typedef enum logic [2:0] {
        LCW_RATE_2M = 3'b000,
        LCW_RATE_4M = 3'b001,
        LCW_RATE_8M = 3'b010,
        LCW_RATE_SUB2 = 3'b011,
        LCW_RATE_SUB4 = 3'b100
    } lcw_rate_t;
    typedef enum logic [0:0] {
        LCW_SCAN_IDLE = 1'b0,
        LCW_SCAN_RUN = 1'b1
    } lcw_scan_t;
endpackage

// [logic/lcw_field_decode.sv]
// field decoder for one local connection word
`timescale 1ns/1ps
`default_nettype none
module lcw_field_decode
    import lcw_pkg::*;
(
    input wire logic [15:0] connWord,
    input wire logic [2:0] localRate,
    input wire logic bp16,
    output logic [2:0] mode,
    output logic srcBackplane,
    output logic varDelay,
    output logic isMessage,
    output logic isPattern,
    output logic isFloat,
    output logic [4:0] srcStream,
    output logic [7:0] srcChannel
);
    // keeps the low n bits of a selector
    function automatic logic [7:0] keepLow(input logic [7:0] v,
                                           input logic [3:0] n);
        keepLow = v & ~(8'hFF << n);
    endfunction

    // ------------------------------------------------------------
    // mode decode
    // ------------------------------------------------------------
    wire lcw_mode_t modeField = lcw_mode_t'(connWord[LCW_MODE_HI:LCW_MODE_LO]);
    wire isSwitch = (modeField[2] == 1'b0);
    wire subRate = (localRate == LCW_RATE_SUB2) ||
                   (localRate == LCW_RATE_SUB4);
    assign mode = modeField;
    assign srcBackplane = (modeField == LCW_MODE_BP_VAR) ||
                          (modeField == LCW_MODE_BP_CONST);
    assign varDelay = (modeField == LCW_MODE_LOC_VAR) ||
                      (modeField == LCW_MODE_BP_VAR);
    assign isMessage = (modeField == LCW_MODE_MESSAGE);
    assign isPattern = (modeField == LCW_MODE_PATTERN);
    assign isFloat = (modeField == LCW_MODE_FLOAT) ||
                     (modeField == LCW_MODE_RSVD);

    // ------------------------------------------------------------
    // selector widths by source and rate
    // ------------------------------------------------------------
    wire [3:0] bpStreamW = bp16 ? LCW_SW_HALF : LCW_SW_FULL;
    wire [3:0] bpChanW = bp16 ? LCW_CW_256 : LCW_CW_128;
    wire [3:0] locStreamW = subRate ? LCW_SW_HALF : LCW_SW_FULL;
    wire [3:0] locChanW =
        (localRate == LCW_RATE_4M) ? LCW_CW_64 :
        (localRate == LCW_RATE_8M) ? LCW_CW_128 :
        (localRate == LCW_RATE_SUB2) ? LCW_CW_128 :
        (localRate == LCW_RATE_SUB4) ? LCW_CW_64 :
        LCW_CW_32;
    wire [3:0] streamW = srcBackplane ? bpStreamW : locStreamW;
    wire [3:0] chanW = srcBackplane ? bpChanW : locChanW;

    // ------------------------------------------------------------
    // masked selectors, zero outside switching modes
    // ------------------------------------------------------------
    wire [7:0] rawStream = {3'b000, connWord[LCW_STRM_HI:LCW_STRM_LO]};
    wire [7:0] maskStream = keepLow(rawStream, streamW);
    wire [7:0] maskChan = keepLow(connWord[LCW_CHAN_HI:LCW_CHAN_LO],
                                  chanW);
    assign srcStream = isSwitch ? maskStream[4:0] : 5'h00;
    assign srcChannel = isSwitch ? maskChan : 8'h00;
endmodule // lcw_field_decode
`default_nettype wire

// [logic/lcw_pair_buffer.sv]
// two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module lcw_pair_buffer #(
    parameter int WIDTH = 32
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    logic headValid_reg;
    logic tailValid_reg;
    logic [WIDTH-1:0] head_reg;
    logic [WIDTH-1:0] tail_reg;

    // handshake terms
    wire push = inValid && inReady;
    wire pop = headValid_reg && outReady;
    wire headFree = pop || !headValid_reg;
    assign inReady = !tailValid_reg;
    assign outValid = headValid_reg;
    assign outData = head_reg;

    // head takes the tail first, then the new word
    always_ff @(posedge mclk) begin
        if (rst) begin
            headValid_reg <= 1'b0;
            tailValid_reg <= 1'b0;
            head_reg <= '0;
            tail_reg <= '0;
        end else if (headFree) begin
            headValid_reg <= tailValid_reg || push;
            head_reg <= tailValid_reg ? tail_reg : inData;
            tailValid_reg <= 1'b0;
        end else if (push) begin
            tail_reg <= inData;
            tailValid_reg <= 1'b1;
        end
    end
endmodule // lcw_pair_buffer
`default_nettype wire

// [logic/lcw_decoder.sv]
// local connection word store, scanner and channel record output
// ------------------------------------------------------------
// Notes on behaviour
// - mode codes: local/backplane, var/const, message, pattern, float
// - word bits 12..8 give source stream
// - word bits 7..0 give source channel
// - message mode sends only low byte
// - backplane 8M: five stream bits, seven channel
// - backplane 16M: four stream bits, eight channel
// - local 2M: five stream bits, five channel
// - local 4M: five stream bits, six channel
// - local 8M: five stream bits, seven channel
// - 2-bit subrate: four stream, seven channel bits
// - 4-bit subrate: four stream, six channel bits
// - 4M/8M local: outputs 19 to 27 held low
// ------------------------------------------------------------
//
// The strobed register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module lcw_decoder
    import lcw_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic [7:0] regAddr,
    input wire logic [15:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [15:0] regRdData,
    output logic chanValid,
    input wire logic chanReady,
    output logic [4:0] chanOutIdx,
    output logic [2:0] chanMode,
    output logic chanSrcBackplane,
    output logic chanVarDelay,
    output logic [4:0] chanSrcStream,
    output logic [7:0] chanSrcChannel,
    output logic [7:0] chanData,
    output logic chanFloat,
    output logic chanDrive
);
    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    localparam int REC_W = 33;
    logic [15:0] connMem_reg [LCW_CHANS];
    logic [15:0] ctrl_reg;
    logic [7:0] lfsr_reg;
    logic [7:0] lfsr_next;
    logic [LCW_IDX_W-1:0] scanIdx_reg;
    logic [LCW_IDX_W-1:0] scanIdx_next;
    logic [7:0] frameCount_reg;
    logic [2:0] lastMode_reg;
    logic [15:0] rdData_reg;
    logic [15:0] rdData_next;
    lcw_scan_t scanState_reg;
    lcw_scan_t scanState_next;

    // ------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------
    // connection words fill the first 32 addresses
    wire hitConn = (regAddr[7:LCW_IDX_W] == LCW_REG_CONN[7:LCW_IDX_W]);
    wire hitCtrl = (regAddr == LCW_REG_CTRL);
    wire hitStat = (regAddr == LCW_REG_STAT);
    wire hitSeed = (regAddr == LCW_REG_SEED);
    wire [LCW_IDX_W-1:0] memIdx = regAddr[LCW_IDX_W-1:0];
    wire wrConn = regWr && hitConn;
    wire wrCtrl = regWr && hitCtrl;
    wire wrSeed = regWr && hitSeed;

    // control fields
    wire [2:0] localRate = ctrl_reg[LCW_CTRL_RATE_LO+2:LCW_CTRL_RATE_LO];
    wire bp16 = ctrl_reg[LCW_CTRL_BP16];
    wire runEn = ctrl_reg[LCW_CTRL_RUN];
    wire lowRate = (localRate == LCW_RATE_4M) ||
                   (localRate == LCW_RATE_8M);

    // ------------------------------------------------------------
    // connection memory and control writes
    // ------------------------------------------------------------
    // reset leaves every channel floating
    always_ff @(posedge mclk) begin
        if (rst) begin
            for (int i = 0; i < LCW_CHANS; i++) begin
                connMem_reg[i] <= LCW_CONN_RST;
            end
        end else if (wrConn) begin
            connMem_reg[memIdx] <= regWrData;
        end
    end

    // control register
    always_ff @(posedge mclk) begin
        if (rst) begin
            ctrl_reg <= LCW_CTRL_RST;
        end else if (wrCtrl) begin
            ctrl_reg <= regWrData;
        end
    end

    // ------------------------------------------------------------
    // scanner
    // ------------------------------------------------------------
    logic bufReady;
    wire issue = (scanState_reg == LCW_SCAN_RUN) && bufReady;
    wire lastIdx = (scanIdx_reg == LCW_IDX_W'(LCW_CHANS - 1));

    // scan state and next index
    always_comb begin
        scanState_next = scanState_reg;
        scanIdx_next = scanIdx_reg;
        case (scanState_reg)
            LCW_SCAN_IDLE: begin
                if (runEn) begin
                    scanState_next = LCW_SCAN_RUN;
                end
                scanIdx_next = '0;
            end
            LCW_SCAN_RUN: begin
                if (issue) begin
                    scanIdx_next = scanIdx_reg + 1'b1;
                end
                // stop only at a frame boundary
                if (!runEn && issue && lastIdx) begin
                    scanState_next = LCW_SCAN_IDLE;
                end
            end
            default: begin
                scanState_next = LCW_SCAN_IDLE;
            end
        endcase
    end

    // scan registers
    always_ff @(posedge mclk) begin
        if (rst) begin
            scanState_reg <= LCW_SCAN_IDLE;
            scanIdx_reg <= '0;
        end else begin
            scanState_reg <= scanState_next;
            scanIdx_reg <= scanIdx_next;
        end
    end

    // ------------------------------------------------------------
    // word decode for the channel in scan
    // ------------------------------------------------------------
    wire [15:0] curWord = connMem_reg[scanIdx_reg];
    logic [2:0] decMode;
    logic decBackplane;
    logic decVarDelay;
    logic decMessage;
    logic decPattern;
    logic decFloat;
    logic [4:0] decStream;
    logic [7:0] decChannel;

    lcw_field_decode u_decode (
        .connWord(curWord),
        .localRate(localRate),
        .bp16(bp16),
        .mode(decMode),
        .srcBackplane(decBackplane),
        .varDelay(decVarDelay),
        .isMessage(decMessage),
        .isPattern(decPattern),
        .isFloat(decFloat),
        .srcStream(decStream),
        .srcChannel(decChannel)
    );

    // ------------------------------------------------------------
    // test pattern generator
    // ------------------------------------------------------------
    // steps once per pattern channel issued
    assign lfsr_next = lfsr_reg[0] ? ((lfsr_reg >> 1) ^ LCW_LFSR_TAPS)
                                   : (lfsr_reg >> 1);
    always_ff @(posedge mclk) begin
        if (rst) begin
            lfsr_reg <= LCW_SEED_RST;
        end else if (wrSeed) begin
            lfsr_reg <= regWrData[7:0];
        end else if (issue && decPattern) begin
            lfsr_reg <= lfsr_next;
        end
    end

    // ------------------------------------------------------------
    // channel record
    // ------------------------------------------------------------
    // unused streams at 4M and 8M are driven low
    wire forceLow = lowRate && (scanIdx_reg >= LCW_LOW_FIRST) &&
                    (scanIdx_reg <= LCW_LOW_LAST);
    wire [7:0] msgByte = curWord[LCW_CHAN_HI:LCW_CHAN_LO];
    wire [7:0] dataByte =
        forceLow ? 8'h00 :
        decMessage ? msgByte :
        decPattern ? lfsr_reg :
        8'h00;
    wire recFloat = decFloat && !forceLow;
    wire recDrive = !recFloat;
    wire [REC_W-1:0] record = {
        scanIdx_reg,
        decMode,
        decBackplane,
        decVarDelay,
        decStream,
        decChannel,
        dataByte,
        recFloat,
        recDrive
    };
    wire [REC_W-1:0] outRec;

    // two-entry buffer toward the stream side
    lcw_pair_buffer #(
        .WIDTH(REC_W)
    ) u_buffer (
        .mclk(mclk),
        .rst(rst),
        .inValid(issue),
        .inReady(bufReady),
        .inData(record),
        .outValid(chanValid),
        .outReady(chanReady),
        .outData(outRec)
    );

    // split the buffered record onto ports
    assign chanOutIdx = outRec[32:28];
    assign chanMode = outRec[27:25];
    assign chanSrcBackplane = outRec[24];
    assign chanVarDelay = outRec[23];
    assign chanSrcStream = outRec[22:18];
    assign chanSrcChannel = outRec[17:10];
    assign chanData = outRec[9:2];
    assign chanFloat = outRec[1];
    assign chanDrive = outRec[0];

    // ------------------------------------------------------------
    // status
    // ------------------------------------------------------------
    // frame count and last mode issued
    always_ff @(posedge mclk) begin
        if (rst) begin
            frameCount_reg <= '0;
            lastMode_reg <= '0;
        end else if (issue) begin
            lastMode_reg <= decMode;
            if (lastIdx) begin
                frameCount_reg <= frameCount_reg + 1'b1;
            end
        end
    end

    wire [15:0] statWord = {
        frameCount_reg,
        3'b000,
        lastMode_reg,
        !bufReady,
        scanState_reg == LCW_SCAN_RUN
    };

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    // unmapped addresses read as zero
    always_comb begin
        rdData_next = 16'h0000;
        if (regRd) begin
            if (hitConn) begin
                rdData_next = connMem_reg[memIdx];
            end else if (hitCtrl) begin
                rdData_next = ctrl_reg;
            end else if (hitStat) begin
                rdData_next = statWord;
            end else if (hitSeed) begin
                rdData_next = {8'h00, lfsr_reg};
            end
        end
    end

    // read data stands one cycle after the strobe
    always_ff @(posedge mclk) begin
        if (rst) begin
            rdData_reg <= 16'h0000;
        end else begin
            rdData_reg <= rdData_next;
        end
    end
    assign regRdData = rdData_reg;
endmodule // lcw_decoder
`default_nettype wire

// [test/lcw_decoder_sva.sv]
// port assertions for the connection word decoder
`timescale 1ns/1ps
`default_nettype none
module lcw_decoder_sva
    import lcw_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic [7:0] regAddr,
    input wire logic [15:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [15:0] regRdData,
    input wire logic chanValid,
    input wire logic chanReady,
    input wire logic [4:0] chanOutIdx,
    input wire logic [2:0] chanMode,
    input wire logic chanSrcBackplane,
    input wire logic chanVarDelay,
    input wire logic [4:0] chanSrcStream,
    input wire logic [7:0] chanSrcChannel,
    input wire logic [7:0] chanData,
    input wire logic chanFloat,
    input wire logic chanDrive
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // outputs in the band that is held low at 4 and 8 Mb/s
    wire logic inLow = chanOutIdx >= LCW_LOW_FIRST &&
        chanOutIdx <= LCW_LOW_LAST;
    wire logic flMode = chanValid && chanMode[2] && chanMode[1];
    // ------------------------------------------------------------
    // register port
    // ------------------------------------------------------------
    sequence s_ctrl_wr; regWr && regAddr == LCW_REG_CTRL; endsequence
    sequence s_ctrl_rd; regRd && regAddr == LCW_REG_CTRL; endsequence
    property p_rd_idle; !regRd |=> regRdData == 16'h0000; endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data not idle");
    property p_ctrl_back;
        s_ctrl_wr ##2 s_ctrl_rd |=>
            (regRdData & 16'h001f) == ($past(regWrData, 3) & 16'h001f);
    endproperty
    a_ctrl_back: assert property (p_ctrl_back)
        else $error("control readback wrong");
    property p_unmapped; regRd && regAddr > LCW_REG_SEED |=> regRdData == 0;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");
    // ------------------------------------------------------------
    // channel records
    // ------------------------------------------------------------
    property p_hold;
        chanValid && !chanReady |=> chanValid && $stable(chanOutIdx) &&
            $stable(chanSrcChannel) && $stable(chanData) &&
            $stable(chanMode) && $stable(chanSrcStream);
    endproperty
    a_hold: assert property (p_hold) else $error("record lost in stall");
    property p_order;
        chanValid && chanReady ##1 chanValid |->
            chanOutIdx == $past(chanOutIdx) + 5'h01;
    endproperty
    a_order: assert property (p_order) else $error("index out of order");
    property p_kind;
        chanValid |-> chanSrcBackplane == (chanMode inside {3'h2, 3'h3}) &&
            chanVarDelay == (chanMode inside {3'h0, 3'h2}) &&
            chanDrive == !chanFloat;
    endproperty
    a_kind: assert property (p_kind) else $error("mode decode wrong");
    property p_float; flMode && !inLow |-> chanFloat; endproperty
    a_float: assert property (p_float) else $error("no float");
    property p_low; flMode && inLow |-> chanFloat || chanData == 8'h00;
    endproperty
    a_low: assert property (p_low) else $error("low band wrong");
    property p_nonsw;
        chanValid && chanMode[2] |-> chanSrcStream == 0 && chanSrcChannel == 0;
    endproperty
    a_nonsw: assert property (p_nonsw) else $error("selectors set");
    property p_data;
        chanValid && chanMode != 3'h4 && chanMode != 3'h5 |-> chanData == 0;
    endproperty
    a_data: assert property (p_data) else $error("data not zero");
    property p_locw; chanValid && chanMode[2:1] == 0 |-> !chanSrcChannel[7];
    endproperty
    a_locw: assert property (p_locw) else $error("channel too wide");
endmodule // lcw_decoder_sva
`default_nettype wire

// [test/lcw_stream_sink.sv]
// stream side model: takes records, stalls in bursts
`timescale 1ns/1ps
`default_nettype none
module lcw_stream_sink (
    input wire logic mclk,
    input wire logic rst,
    input wire logic chanValid,
    output logic chanReady
);
    logic [4:0] cntReg;
    // random ready, eight-cycle stall every 32 to fill the buffer
    always @(posedge mclk) begin
        if (rst) begin
            cntReg <= 5'h00;
            chanReady <= 1'b0;
        end else begin
            cntReg <= cntReg + 5'h01;
            chanReady <= (cntReg[4:3] != 2'b11) && ($urandom % 4 != 0);
        end
    end
endmodule // lcw_stream_sink
`default_nettype wire

// [test/test_lcw_decoder.sv]
// testbench for the connection word decoder
`timescale 1ns/1ps
`default_nettype none
module test_lcw_decoder
    import lcw_pkg::*;
;
    logic mclk = 0, rst = 1, regWr = 0, regRd = 0, rdPend = 0;
    logic [7:0] regAddr = 8'h00;
    logic [15:0] regWrData = 16'h0000, w, ctl;
    wire logic [15:0] regRdData;
    wire logic chanValid, chanReady, chanSrcBackplane, chanVarDelay;
    wire logic chanFloat, chanDrive;
    wire logic [4:0] chanOutIdx, chanSrcStream;
    wire logic [2:0] chanMode;
    wire logic [7:0] chanSrcChannel, chanData;
    logic [33:0] recQ[$];
    logic [15:0] rdQ[$];
    logic [15:0] wm [32];
    logic [32:0] got, mk;
    logic [33:0] e;
    logic [15:0] er;
    int errors = 0, compares = 0, n, seedDummy;
    always #4 mclk = ~mclk;
    lcw_decoder lcw_decoder_i (.mclk(mclk), .rst(rst), .regAddr(regAddr),
        .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
        .regRdData(regRdData), .chanValid(chanValid), .chanReady(chanReady),
        .chanOutIdx(chanOutIdx), .chanMode(chanMode),
        .chanSrcBackplane(chanSrcBackplane), .chanVarDelay(chanVarDelay),
        .chanSrcStream(chanSrcStream), .chanSrcChannel(chanSrcChannel),
        .chanData(chanData), .chanFloat(chanFloat), .chanDrive(chanDrive));
    lcw_stream_sink lcw_stream_sink_i (.mclk(mclk), .rst(rst),
        .chanValid(chanValid), .chanReady(chanReady));
    // ------------------------------------------------------------
    // bus tasks and expected record
    // ------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge mclk);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'b1;
        @(posedge mclk);
        regWr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] x);
        @(posedge mclk);
        regAddr <= a;
        regRd <= 1'b1;
        rdQ.push_back(x);
        @(posedge mclk);
        regRd <= 1'b0;
    endtask
    function automatic logic [33:0] expv(logic [4:0] i, logic [15:0] w,
        logic [2:0] r, logic bp);
        logic [2:0] m;
        logic [7:0] sm, cm, d;
        logic lo, fl;
        m = w[15:13];
        sm = 8'h1f;
        cm = 8'h1f;
        case (r)
            3'h1: cm = 8'h3f;
            3'h2: cm = 8'h7f;
            3'h3: begin sm = 8'h0f; cm = 8'h7f; end
            3'h4: begin sm = 8'h0f; cm = 8'h3f; end
            default: ;
        endcase
        if (m[1]) begin
            sm = bp ? 8'h0f : 8'h1f;
            cm = bp ? 8'hff : 8'h7f;
        end
        if (m[2]) begin
            sm = 8'h00;
            cm = 8'h00;
        end
        lo = (r == 3'h1 || r == 3'h2) && i >= 5'h13 && i <= 5'h1b;
        d = (m == 3'h4 && !lo) ? w[7:0] : 8'h00;
        fl = m[2] && m[1] && !lo;
        return {m == 3'h5, i, m, m == 3'h2 || m == 3'h3, m == 3'h0 || m == 3'h2,
            w[12:8] & sm[4:0], w[7:0] & cm, d, fl, !fl};
    endfunction
    // ------------------------------------------------------------
    // monitor: oldest note against each result
    // ------------------------------------------------------------
    always @(posedge mclk) begin
        if (rdPend) begin
            er = rdQ.pop_front();
            compares++;
            if (regRdData !== er) begin
                errors++;
                $display("unexpected %0t: read %h not %h", $time, regRdData, er);
            end
        end
        rdPend = regRd && !rst;
        if (!rst && chanValid && chanReady) begin
            got = {chanOutIdx, chanMode, chanSrcBackplane, chanVarDelay,
                chanSrcStream, chanSrcChannel, chanData, chanFloat, chanDrive};
            compares++;
            if (recQ.size() == 0) begin
                errors++;
                $display("unexpected %0t: extra record %h", $time, got);
            end else begin
                e = recQ.pop_front();
                mk = e[33] ? ~33'h0_0000_03fc : ~33'h0; // pattern byte free
                if ((got & mk) !== (e[32:0] & mk)) begin
                    errors++;
                    $display("unexpected %0t: record %h not %h", $time, got, e);
                end
            end
        end
    end
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // watchdog sized well above eight scan runs
    initial begin
        #(8 * 40000);
        errors++;
        $display("unexpected %0t: watchdog expired", $time);
        end_of_test();
    end
    // ------------------------------------------------------------
    // main sequence: reset values, then one scan per rate code
    // ------------------------------------------------------------
    initial begin
        seedDummy = $urandom(32'hba34);
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        rd(LCW_REG_CONN, LCW_CONN_RST);
        rd(LCW_REG_CTRL, LCW_CTRL_RST);
        wr(8'h30, 16'hffff);
        rd(8'h30, 16'h0000);
        rd(LCW_REG_SEED, {8'h00, LCW_SEED_RST});
        wr(LCW_REG_SEED, 16'h00a5);
        rd(LCW_REG_SEED, 16'h00a5);
        $display("test reset values done");
        for (int r = 0; r < 8; r++) begin
            for (int i = 0; i < 32; i++) begin
                w = {3'(i % 8), 13'($urandom)};
                wm[i] = w;
                wr(8'(i), w);
                recQ.push_back(expv(5'(i), w, 3'(r), r[0]));
            end
            rd(8'h05, wm[5]); // earlier word reads back
            rd(8'h1f, w); // last word reads back
            ctl = {11'h000, 1'b1, r[0], 3'(r)};
            wr(LCW_REG_CTRL, ctl);
            wr(LCW_REG_CTRL, ctl & 16'hffef);
            rd(LCW_REG_CTRL, ctl & 16'hffef);
            n = 0;
            while (recQ.size() > 0 && n < 4000) begin
                @(posedge mclk);
                n++;
            end
            repeat (12) @(posedge mclk);
            rd(LCW_REG_STAT, {8'(r + 1), 8'h1c}); // r + 1 frames so far, mode 7 last
            if (recQ.size() != 0) begin
                errors++;
                $display("unexpected %0t: records missing", $time);
            end
            $display("test rate %0d done", r);
        end
        repeat (2) @(posedge mclk);
        end_of_test();
    end
endmodule // test_lcw_decoder
bind lcw_decoder lcw_decoder_sva lcw_decoder_sva_i (.mclk(mclk), .rst(rst),
    .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .chanValid(chanValid), .chanReady(chanReady),
    .chanOutIdx(chanOutIdx), .chanMode(chanMode),
    .chanSrcBackplane(chanSrcBackplane), .chanVarDelay(chanVarDelay),
    .chanSrcStream(chanSrcStream), .chanSrcChannel(chanSrcChannel),
    .chanData(chanData), .chanFloat(chanFloat), .chanDrive(chanDrive));
`default_nettype wire
